// >>> design/vcom_pkg.sv
// Shared constants for the serial bridge link: frame, baud, register map.
// Assumes a single 20 MHz clock on both ends.
package vcom_pkg;
  localparam int CLOCK_HZ     = 20_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BAUD_MIN     = 9_600;
  localparam int BAUD_MAX     = 921_600;
  localparam int DATA_BITS    = 8;
  localparam int STOP_BITS    = 1;

  localparam logic [15:0] DIV_DEFAULT = 16'((CLOCK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [15:0] DIV_MAX     = 16'(CLOCK_HZ / BAUD_MIN);
  localparam logic [15:0] DIV_MIN     = 16'((CLOCK_HZ + BAUD_MAX - 1) / BAUD_MAX);
  localparam logic [3:0]  FRAME_BITS  = 4'(DATA_BITS + STOP_BITS + 1);

  typedef enum logic [1:0] {
    HS_DISABLED = 2'b00,
    HS_RTS      = 2'b01,
    HS_CTS      = 2'b10,
    HS_RTSCTS   = 2'b11
  } handshake_type;

  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_BAUD_DIV  = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_TX_DATA   = 8'h0C;
  localparam logic [7:0] OFS_RX_USB    = 8'h10;
  localparam logic [7:0] OFS_RX_SOCKET = 8'h14;

  localparam int CTRL_SOCKET_BIT = 2;
  localparam int RX_VALID_BIT    = 8;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Bridge drives its ready pin in these modes
  function automatic logic drives_ready(input handshake_type mode);
    return (mode == HS_RTS) || (mode == HS_RTSCTS);
  endfunction

  // Bridge obeys the target's ready pin in these modes
  function automatic logic obeys_ready(input handshake_type mode);
    return (mode == HS_CTS) || (mode == HS_RTSCTS);
  endfunction
endpackage

// >>> design/vcom_if.sv
// Serial link between the target end and the bridge end.
// Assumes an idle-high pull-up on the bridge ready line when undriven.
`timescale 1ns/1ps
interface vcom_if;
  logic t2b;
  logic b2t;
  logic target_ready;
  logic pass_enable;
  logic bridge_ready_out;
  logic bridge_ready_oe_n;
  logic bridge_ready;

  // Pull-up when the bridge leaves the line undriven
  assign bridge_ready = bridge_ready_oe_n ? 1'b1 : bridge_ready_out;

  modport bridge_end (
    input  t2b,
    input  target_ready,
    input  pass_enable,
    output b2t,
    output bridge_ready_out,
    output bridge_ready_oe_n
  );

  modport target_end (
    output t2b,
    output target_ready,
    output pass_enable,
    input  b2t,
    input  bridge_ready
  );
endinterface

// >>> design/vcom_target.sv
// Target end: byte-wide UART with optional hardware handshake.
// Assumes link pins come from another party and are synchronised here.
`timescale 1ns/1ps
module vcom_target
  import vcom_pkg::*;
#(
  parameter logic [15:0] DIV       = vcom_pkg::DIV_DEFAULT,
  parameter bit          HANDSHAKE = 1'b0
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  vcom_if.target_end      link,
  input  wire logic       enable,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  import vcom_pkg::*;

  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic       line;
  logic       peer_ready;
  logic       tx_busy;
  logic [9:0] tx_shift;
  logic [3:0] tx_bits;
  logic [15:0] tx_cnt;
  logic       rx_busy;
  logic [3:0] rx_bits;
  logic [15:0] rx_cnt;
  logic [7:0] rx_shift;

  assign link.pass_enable  = enable;
  assign link.target_ready = rx_ready;
  assign link.t2b          = tx_shift[0];
  assign line              = sync_b[0];
  assign peer_ready        = sync_b[1];
  assign tx_ready = !tx_busy && enable && (!HANDSHAKE || peer_ready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 2'b11;
      sync_b <= 2'b11;
    end else begin
      sync_a <= {link.bridge_ready, link.b2t};
      sync_b <= sync_a;
    end
  end

  // Transmitter: start, data LSB first, stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy  <= 1'b0;
      tx_shift <= 10'h3FF;
      tx_bits  <= 4'h0;
      tx_cnt   <= 16'h0000;
    end else if (tx_ready && tx_valid) begin
      tx_shift <= {1'b1, tx_data, 1'b0};
      tx_bits  <= FRAME_BITS;
      tx_cnt   <= DIV - 16'h0001;
      tx_busy  <= 1'b1;
    end else if (tx_busy) begin
      if (tx_cnt == 16'h0000) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bits  <= tx_bits - 4'h1;
        tx_cnt   <= DIV - 16'h0001;
        if (tx_bits == 4'h1) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_cnt <= tx_cnt - 16'h0001;
      end
    end
  end

  // Receiver: samples mid-bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy  <= 1'b0;
      rx_bits  <= 4'h0;
      rx_cnt   <= 16'h0000;
      rx_shift <= 8'h00;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (!line) begin
          rx_busy <= 1'b1;
          rx_bits <= FRAME_BITS;
          rx_cnt  <= {1'b0, DIV[15:1]};
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt  <= DIV - 16'h0001;
        rx_bits <= rx_bits - 4'h1;
        if (rx_bits == FRAME_BITS) begin
          if (line) begin
            rx_busy <= 1'b0;
          end
        end else if (rx_bits != 4'h1) begin
          rx_shift <= {line, rx_shift[7:1]};
        end else begin
          rx_busy <= 1'b0;
          if (line) begin
            rx_data  <= rx_shift;
            rx_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// >>> design/vcom_bridge.sv
// Bridge end: UART toward the target, AXI4-Lite registers toward software,
// two-entry receive buffer, four handshake modes, two host read paths.
// Assumes target pins are asynchronous and are synchronised here.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module vcom_bridge
  import vcom_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  vcom_if.bridge_end       link,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import vcom_pkg::*;

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  handshake_type mode;
  logic          socket_path;
  logic [15:0]   baud_div;
  logic [2:0]    sync_a;
  logic [2:0]    sync_b;
  logic          line;
  logic          ready_s;
  logic          pass_s;
  logic [7:0]    tx_hold;
  logic          tx_hold_valid;
  logic          tx_start;
  logic          tx_busy;
  logic [9:0]    tx_shift;
  logic [3:0]    tx_bits;
  logic [15:0]   tx_cnt;
  logic          rx_busy;
  logic [3:0]    rx_bits;
  logic [15:0]   rx_cnt;
  logic [7:0]    rx_shift;
  logic          rx_push;
  logic [7:0]    mem [DEPTH];
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic [CW-1:0] count;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic          fifo_pop;
  logic          aw_got;
  logic          w_got;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          do_write;
  logic          tx_write;
  logic [7:0]    rx_ofs;
  logic [31:0]   next_rdata;
  logic [1:0]    next_rresp;
  logic [15:0]   new_div;

  assign line    = sync_b[0];
  assign ready_s = sync_b[1];
  assign pass_s  = sync_b[2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 3'b011;
      sync_b <= 3'b011;
    end else begin
      sync_a <= {link.pass_enable, link.target_ready, link.t2b};
      sync_b <= sync_a;
    end
  end

  // Handshake pins
  assign fifo_in_ready  = (count != CW'(DEPTH));
  assign fifo_out_valid = (count != '0);
  assign link.bridge_ready_oe_n = !drives_ready(mode);
  assign link.bridge_ready_out  = (count < CW'(DEPTH - 1));
  assign link.b2t = tx_shift[0];

  // Transmitter toward target
  assign tx_start = !tx_busy && tx_hold_valid && pass_s
                    && (!obeys_ready(mode) || ready_s);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy  <= 1'b0;
      tx_shift <= 10'h3FF;
      tx_bits  <= 4'h0;
      tx_cnt   <= 16'h0000;
    end else if (tx_start) begin
      tx_shift <= {1'b1, tx_hold, 1'b0};
      tx_bits  <= FRAME_BITS;
      tx_cnt   <= baud_div - 16'h0001;
      tx_busy  <= 1'b1;
    end else if (tx_busy) begin
      if (tx_cnt == 16'h0000) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bits  <= tx_bits - 4'h1;
        tx_cnt   <= baud_div - 16'h0001;
        if (tx_bits == 4'h1) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_cnt <= tx_cnt - 16'h0001;
      end
    end
  end

  // Receiver from target, mid-bit sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy  <= 1'b0;
      rx_bits  <= 4'h0;
      rx_cnt   <= 16'h0000;
      rx_shift <= 8'h00;
      rx_push  <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (!rx_busy) begin
        if (!line && pass_s) begin
          rx_busy <= 1'b1;
          rx_bits <= FRAME_BITS;
          rx_cnt  <= {1'b0, baud_div[15:1]};
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt  <= baud_div - 16'h0001;
        rx_bits <= rx_bits - 4'h1;
        if (rx_bits == FRAME_BITS) begin
          if (line) begin
            rx_busy <= 1'b0;
          end
        end else if (rx_bits != 4'h1) begin
          rx_shift <= {line, rx_shift[7:1]};
        end else begin
          rx_busy <= 1'b0;
          rx_push <= line;
        end
      end
    end
  end

  // Two-entry receive buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (rx_push && fifo_in_ready) begin
        wr_idx <= (wr_idx == IW'(DEPTH - 1)) ? '0 : wr_idx + IW'(1);
      end
      if (fifo_pop) begin
        rd_idx <= (rd_idx == IW'(DEPTH - 1)) ? '0 : rd_idx + IW'(1);
      end
      count <= count + CW'(rx_push && fifo_in_ready) - CW'(fifo_pop);
    end
  end

  always_ff @(posedge aclk) begin
    if (rx_push && fifo_in_ready) begin
      mem[wr_idx] <= rx_shift;
    end
  end

  // AXI4-Lite write channel
  assign awready  = !aw_got && !bvalid;
  assign wready   = !w_got && !bvalid;
  assign tx_write = (aw_addr == OFS_TX_DATA);
  assign do_write = aw_got && w_got && !bvalid && !(tx_write && tx_hold_valid);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got  <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (aw_addr == OFS_CTRL || aw_addr == OFS_BAUD_DIV || tx_write)
                  ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Clamp divisor to the supported baud range
  assign new_div = (w_data[15:0] > DIV_MAX) ? DIV_MAX :
                   (w_data[15:0] < DIV_MIN) ? DIV_MIN : w_data[15:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode        <= HS_DISABLED;
      socket_path <= 1'b0;
      baud_div    <= DIV_DEFAULT;
    end else if (do_write) begin
      if (aw_addr == OFS_CTRL && w_strb[0]) begin
        mode        <= handshake_type'(w_data[1:0]);
        socket_path <= w_data[CTRL_SOCKET_BIT];
      end
      if (aw_addr == OFS_BAUD_DIV && w_strb[1:0] == 2'b11) begin
        baud_div <= new_div;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_valid <= 1'b0;
      tx_hold       <= 8'h00;
    end else if (do_write && tx_write && w_strb[0]) begin
      tx_hold_valid <= 1'b1;
      tx_hold       <= w_data[7:0];
    end else if (tx_start) begin
      tx_hold_valid <= 1'b0;
    end
  end

  // AXI4-Lite read channel; only the active host path sees data
  assign rx_ofs   = socket_path ? OFS_RX_SOCKET : OFS_RX_USB;
  assign arready  = !rvalid;
  assign fifo_pop = arvalid && arready && (araddr == rx_ofs) && fifo_out_valid;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    case (araddr)
      OFS_CTRL: begin
        next_rdata[1:0]             = mode;
        next_rdata[CTRL_SOCKET_BIT] = socket_path;
      end
      OFS_BAUD_DIV: begin
        next_rdata[15:0] = baud_div;
      end
      OFS_STATUS: begin
        next_rdata[6:0] = {link.bridge_ready_out, pass_s, ready_s,
                           !fifo_in_ready, fifo_out_valid, tx_busy, tx_hold_valid};
      end
      OFS_TX_DATA: begin
        next_rdata[7:0] = tx_hold;
      end
      OFS_RX_USB, OFS_RX_SOCKET: begin
        if (araddr == rx_ofs && fifo_out_valid) begin
          next_rdata[RX_VALID_BIT] = 1'b1;
          next_rdata[7:0]          = mem[rd_idx];
        end
      end
      default: begin
        next_rresp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// >>> sim/vcom_uart_flow_control_assertions.sv
// Checker for the serial link between the target end and the bridge end.
// Assumes both ends run at the bit time DIV that the bench sets.
`timescale 1ns/1ps
module vcom_uart_flow_control_assertions #(
  parameter int DIV = 22
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic t2b,
  input wire logic b2t,
  input wire logic target_ready,
  input wire logic pass_enable,
  input wire logic bridge_ready_out,
  input wire logic bridge_ready_oe_n,
  input wire logic bridge_ready
);
  localparam int MID  = DIV / 2;
  localparam int STOP = 9 * DIV + DIV / 2;
  localparam int LAST = 10 * DIV - 1;
  logic [11:0] b_cnt;
  logic [11:0] t_cnt;

  // Cycles since the start edge of a frame, zero while idle
  always_ff @(posedge aclk) begin
    if (!aresetn || b_cnt == 12'(LAST)) begin
      b_cnt <= 12'h000;
    end else if (b_cnt != 12'h000 || !b2t) begin
      b_cnt <= b_cnt + 12'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || t_cnt == 12'(LAST)) begin
      t_cnt <= 12'h000;
    end else if (t_cnt != 12'h000 || !t2b) begin
      t_cnt <= t_cnt + 12'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_idle_line:
    assert property ($rose(aresetn) |-> b2t && t2b && bridge_ready_oe_n)
    else $error("link not idle after reset");
  a_start_bit_low:
    assert property (b_cnt == MID |-> !b2t) else $error("bridge start bit not low");
  a_stop_bit_high:
    assert property (b_cnt == STOP |-> b2t) else $error("bridge stop bit not high");
  a_target_stop_high:
    assert property (t_cnt == STOP |-> t2b) else $error("target stop bit not high");
  a_bit_time_min:
    assert property ($rose(b2t) |-> b2t [*8]) else $error("bridge bit too short");
  a_target_bit_min:
    assert property ($fell(t2b) |-> !t2b [*8]) else $error("target bit too short");
  a_no_start_disabled:
    assert property (!pass_enable [*6] ##1 b_cnt == 0 |-> b2t)
    else $error("bridge started while pass disabled");
  a_target_holds_off:
    assert property (!bridge_ready [*6] ##1 t_cnt == 0 |-> t2b)
    else $error("target started while bridge not ready");
  a_ready_drop_cause:
    assert property ($fell(bridge_ready_out) |-> t2b && $past(t2b))
    else $error("bridge ready dropped outside a stop bit");

  c_bridge_frame: cover property (b_cnt == STOP);
  c_target_frame: cover property (t_cnt == STOP);
  c_ready_drop: cover property ($fell(bridge_ready_out));
  c_cts_held: cover property (!target_ready && !b2t);
endmodule

// >>> sim/vcom_uart_flow_control_tb.sv
// Testbench: target end and bridge end joined by the link interface.
// Assumes the register map, divisor limits and response codes of vcom_pkg.
`timescale 1ns/1ps
module vcom_uart_flow_control_tb;
  import vcom_pkg::*;
  localparam int DIV_CYC = 22;
  localparam int LIMIT   = 60000;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic        enable = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1, tx_ready, rx_valid;
  logic [7:0]  tx_data = 8'h00, rx_data, awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, mode;
  logic [7:0]  rxq[$];
  int          errors = 0, compares = 0, cycles = 0;

  vcom_if link ();
  vcom_target #(.DIV(16'(DIV_CYC)), .HANDSHAKE(1'b1)) i_vcom_target (
    .aclk(aclk), .aresetn(aresetn), .link(link), .enable(enable), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready));
  vcom_bridge i_vcom_bridge (
    .aclk(aclk), .aresetn(aresetn), .link(link), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  vcom_uart_flow_control_assertions #(.DIV(DIV_CYC)) i_checker (
    .aclk(aclk), .aresetn(aresetn), .t2b(link.t2b), .b2t(link.b2t),
    .target_ready(link.target_ready), .pass_enable(link.pass_enable),
    .bridge_ready_out(link.bridge_ready_out), .bridge_ready_oe_n(link.bridge_ready_oe_n),
    .bridge_ready(link.bridge_ready));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (cycles == LIMIT) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_left;
    logic w_left;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_left = 1'b1;
    w_left  = 1'b1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && awready === 1'b1) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic tgt_tx(input logic [7:0] b);
    @(posedge aclk);
    tx_data  <= b;
    tx_valid <= 1'b1;
    do @(posedge aclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask

  task automatic wait_rx(input logic [7:0] b);
    while (rxq.size() == 0) @(posedge aclk);
    chk("target rx byte", {24'h0, b}, {24'h0, rxq.pop_front()});
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    rdc(OFS_BAUD_DIV, 32'(DIV_DEFAULT), RESP_OKAY);
    rdc(8'h18, 32'h0000_0000, RESP_SLVERR);
    axi_wr(8'h20, 32'h0000_0001, RESP_SLVERR);
    axi_wr(OFS_BAUD_DIV, 32'h0000_FFFF, RESP_OKAY);
    rdc(OFS_BAUD_DIV, 32'(DIV_MAX), RESP_OKAY);
    axi_wr(OFS_BAUD_DIV, 32'(DIV_CYC), RESP_OKAY);
    rdc(OFS_BAUD_DIV, 32'(DIV_CYC), RESP_OKAY);
    axi_wr(OFS_TX_DATA, 32'h0000_00A5, RESP_OKAY);
    repeat (400) @(posedge aclk);
    chk("gated rx count", 32'h0, 32'(rxq.size()));
    enable <= 1'b1;
    wait_rx(8'hA5);
    // Each mode with the target refusing: only obeying modes hold the byte
    for (int i = 0; i < 4; i++) begin
      mode = 2'(i);
      axi_wr(OFS_CTRL, {30'h0, mode}, RESP_OKAY);
      chk("oe_n", {31'h0, ~mode[0]}, {31'h0, link.bridge_ready_oe_n});
      rx_ready <= 1'b0;
      axi_wr(OFS_TX_DATA, {24'h0, 8'h30 + 8'(mode)}, RESP_OKAY);
      repeat (400) @(posedge aclk);
      chk("held rx count", {31'h0, ~mode[1]}, 32'(rxq.size()));
      rx_ready <= 1'b1;
      if (mode[1]) begin
        while (link.b2t !== 1'b0) @(posedge aclk);
        rx_ready <= 1'b0;
      end
      wait_rx(8'h30 + 8'(mode));
      rx_ready <= 1'b1;
    end
    axi_wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    tgt_tx(8'h5A);
    while (link.bridge_ready !== 1'b0) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk("tx_ready held", 32'h0, {31'h0, tx_ready});
    // One byte held, peer ready and pass seen, bridge ready low
    rdc(OFS_STATUS, 32'h0000_0034, RESP_OKAY);
    rdc(OFS_RX_USB, 32'h0000_015A, RESP_OKAY);
    tgt_tx(8'hC3);
    while (link.bridge_ready !== 1'b0) @(posedge aclk);
    rdc(OFS_RX_USB, 32'h0000_01C3, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h0000_0005, RESP_OKAY);
    tgt_tx(8'h96);
    while (link.bridge_ready !== 1'b0) @(posedge aclk);
    rdc(OFS_RX_USB, 32'h0000_0000, RESP_OKAY);
    rdc(OFS_RX_SOCKET, 32'h0000_0196, RESP_OKAY);
    test_done();
  end
endmodule
